/* jfa_pkg.sv */
// Constants and types shared by the JTAG flash access block
package jfa_pkg;

	localparam int CTRL_W = 8;
	localparam int DATA_W = 10;
	localparam int ADDR_W = 17;
	localparam int BYTE_W = 8;
	localparam int WMODE_W = 3;
	localparam int RMODE_W = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int CTRL_SCRATCH_BIT = 7;
	localparam int CTRL_WMODE_LSB = 4;
	localparam int CTRL_RMODE_LSB = 0;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

	localparam logic [WMODE_W-1:0] WMODE_STORE = 3'h0;
	localparam logic [WMODE_W-1:0] WMODE_PROGRAM = 3'h1;
	localparam logic [WMODE_W-1:0] WMODE_ERASE = 3'h2;

	localparam logic [RMODE_W-1:0] RMODE_PLAIN = 4'h0;
	localparam logic [RMODE_W-1:0] RMODE_BLOCK = 4'h1;
	localparam logic [RMODE_W-1:0] RMODE_SINGLE = 4'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Data register fields
	localparam int DATA_BYTE_LSB = 2;
	localparam int DATA_FAIL_BIT = 1;
	localparam int DATA_BUSY_BIT = 0;
	localparam logic [BYTE_W-1:0] DATA_BYTE_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;

	////////////////////////////////////////////////////////////////////////////////
	// Erase key and address map
	localparam logic [BYTE_W-1:0] ERASE_KEY = 8'ha5;
	localparam logic [ADDR_W-1:0] MASS_ERASE_ADDR_LO = 17'h1fbfe;
	localparam logic [ADDR_W-1:0] MASS_ERASE_ADDR_HI = 17'h1fbff;
	localparam logic [ADDR_W-1:0] RESERVED_BASE = 17'h1fc00;
	localparam int SCRATCH_SECTOR_BYTES = 128;

	////////////////////////////////////////////////////////////////////////////////
	// Synchronised link inputs
	localparam int SYNC_STAGES = 2;
	localparam int LINK_W = 8;
	localparam int LNK_TCK = 0;
	localparam int LNK_TDI = 1;
	localparam int LNK_SEL_CTRL = 2;
	localparam int LNK_SEL_DATA = 3;
	localparam int LNK_SEL_ADDR = 4;
	localparam int LNK_CAPTURE = 5;
	localparam int LNK_SHIFT = 6;
	localparam int LNK_UPDATE = 7;

	typedef enum logic [1:0] {
		JFA_CMD_READ,
		JFA_CMD_PROGRAM,
		JFA_CMD_PAGE_ERASE,
		JFA_CMD_MASS_ERASE
	} jfa_cmd_e;

	typedef enum logic {
		JFA_ST_IDLE,
		JFA_ST_WAIT
	} jfa_state_e;

endpackage

/* jfa_sync.sv */
// Two-flop synchroniser bank for the link inputs
`timescale 1ns/1ns
module jfa_sync import jfa_pkg::*; #(
	parameter int WIDTH = LINK_W
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					meta_r[g] <= 1'b0;
					o_sync[g] <= 1'b0;
				end else begin
					meta_r[g] <= i_async[g];
					o_sync[g] <= meta_r[g];
				end
			end
		end
	endgenerate

endmodule

/* jfa_flash_access.sv */
// JTAG flash access: control, address and data registers with the flash sequencer
`timescale 1ns/1ns
// Functional notes
// - Scratch select 1 sends accesses to two 128-byte scratch sectors, else main array.
// - Write mode 000: data register write only stores the byte.
// - Write mode 001: program the byte at held address, then address plus one.
// - Write mode 010: key 0xa5 erases page of held address; address unchanged.
// - Erase at 0x1fbfe or 0x1fbff erases user space, reserved area from 0x1fc00 kept.
// - Data register lets the host read and write flash bytes.
// - Data register is 10 bits, byte in bits 9 to 2.
// - Data bit 1 reports the outcome of the last flash operation.
// - Fail bit reads 0 after success, 1 after a failed operation.
// - Bit 0 reads 1 while busy; accesses then start no new operation.
module jfa_flash_access import jfa_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_tck,
	input wire logic i_tdi,
	input wire logic i_sel_ctrl,
	input wire logic i_sel_data,
	input wire logic i_sel_addr,
	input wire logic i_capture_dr,
	input wire logic i_shift_dr,
	input wire logic i_update_dr,
	output logic o_tdo,
	output logic o_flash_req,
	output jfa_cmd_e o_flash_cmd,
	output logic [ADDR_W-1:0] o_flash_addr,
	output logic [BYTE_W-1:0] o_flash_wdata,
	output logic o_flash_scratch,
	input wire logic i_flash_done,
	input wire logic i_flash_fail,
	input wire logic [BYTE_W-1:0] i_flash_rdata
);

	logic [LINK_W-1:0] link_raw;
	logic [LINK_W-1:0] link_s;
	logic tck_d_r;
	logic tck_rise;
	logic cap_ev;
	logic shift_ev;
	logic upd_ev;
	logic [ADDR_W-1:0] sr_r;
	logic [CTRL_W-1:0] ctrl_r;
	logic [ADDR_W-1:0] addr_r;
	logic [BYTE_W-1:0] byte_r;
	logic fail_r;
	logic unread_r;
	logic op_prog_r;
	logic op_read_r;
	jfa_state_e state_r;
	logic idle;
	logic [WMODE_W-1:0] wmode;
	logic [RMODE_W-1:0] rmode;
	logic [BYTE_W-1:0] wbyte;
	logic data_wr;
	logic start_read;
	logic start_prog;
	logic start_erase;
	logic mass_erase;
	logic start_any;
	logic data_sel;
	logic addr_sel;

	////////////////////////////////////////////////////////////////////////////////
	// Link sampling; the 80 ns link clock is oversampled, so edges are never missed
	assign link_raw = {i_update_dr, i_shift_dr, i_capture_dr, i_sel_addr,
		i_sel_data, i_sel_ctrl, i_tdi, i_tck};

	jfa_sync #(.WIDTH(LINK_W)) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_async(link_raw),
		.o_sync(link_s)
	);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tck_d_r <= 1'b0;
		end else begin
			tck_d_r <= link_s[LNK_TCK];
		end
	end

	assign tck_rise = link_s[LNK_TCK] & ~tck_d_r;
	assign cap_ev = tck_rise & link_s[LNK_CAPTURE];
	assign shift_ev = tck_rise & link_s[LNK_SHIFT];
	assign upd_ev = tck_rise & link_s[LNK_UPDATE];

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	assign idle = (state_r == JFA_ST_IDLE);
	// Control select outranks data, data outranks address, as for the shift register
	assign data_sel = link_s[LNK_SEL_DATA] & ~link_s[LNK_SEL_CTRL];
	assign addr_sel = link_s[LNK_SEL_ADDR] & ~link_s[LNK_SEL_DATA] & ~link_s[LNK_SEL_CTRL];
	assign wmode = ctrl_r[CTRL_WMODE_LSB +: WMODE_W];
	assign rmode = ctrl_r[CTRL_RMODE_LSB +: RMODE_W];
	assign wbyte = sr_r[DATA_BYTE_LSB +: BYTE_W];
	// Writes while busy are dropped whole, stored byte included
	assign data_wr = upd_ev & data_sel & idle;
	assign start_read = cap_ev & data_sel & idle
		& ((rmode == RMODE_BLOCK) | ((rmode == RMODE_SINGLE) & ~unread_r));
	assign start_prog = data_wr & (wmode == WMODE_PROGRAM);
	// Undefined write modes only store the byte, like mode 000
	assign start_erase = data_wr & (wmode == WMODE_ERASE) & (wbyte == ERASE_KEY);
	assign mass_erase = (addr_r == MASS_ERASE_ADDR_LO) | (addr_r == MASS_ERASE_ADDR_HI);
	assign start_any = start_read | start_prog | start_erase;

	////////////////////////////////////////////////////////////////////////////////
	// Shift register and test data out
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sr_r <= ADDR_RESET;
		end else if (cap_ev) begin
			if (link_s[LNK_SEL_CTRL]) begin
				sr_r <= {{(ADDR_W-CTRL_W){1'b0}}, ctrl_r};
			end else if (link_s[LNK_SEL_DATA]) begin
				sr_r <= {{(ADDR_W-DATA_W){1'b0}}, byte_r, fail_r, ~idle};
			end else begin
				sr_r <= addr_r;
			end
		end else if (shift_ev) begin
			if (link_s[LNK_SEL_CTRL]) begin
				sr_r[CTRL_W-1:0] <= {link_s[LNK_TDI], sr_r[CTRL_W-1:1]};
			end else if (link_s[LNK_SEL_DATA]) begin
				sr_r[DATA_W-1:0] <= {link_s[LNK_TDI], sr_r[DATA_W-1:1]};
			end else begin
				sr_r <= {link_s[LNK_TDI], sr_r[ADDR_W-1:1]};
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_tdo <= 1'b0;
		end else begin
			o_tdo <= sr_r[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register; writable at any time, modes are latched per operation
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_r <= CTRL_RESET;
		end else if (upd_ev & link_s[LNK_SEL_CTRL]) begin
			ctrl_r <= sr_r[CTRL_W-1:0];
		end
	end

	// Address register
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			addr_r <= ADDR_RESET;
		end else if (~idle & i_flash_done & op_prog_r) begin
			addr_r <= addr_r + 17'h00001;
		end else if (upd_ev & addr_sel & idle) begin
			addr_r <= sr_r;
		end
	end

	// Data byte, fail flag and unread marker
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			byte_r <= DATA_BYTE_RESET;
			fail_r <= 1'b0;
		end else if (~idle & i_flash_done) begin
			fail_r <= i_flash_fail;
			if (op_read_r) begin
				byte_r <= i_flash_rdata;
			end
		end else if (data_wr) begin
			byte_r <= wbyte;
		end
	end

	// A read landing in the same cycle as a capture stays unread
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			unread_r <= 1'b0;
		end else if (~idle & i_flash_done & op_read_r & ~i_flash_fail) begin
			unread_r <= 1'b1;
		end else if (cap_ev & data_sel) begin
			unread_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= JFA_ST_IDLE;
			op_prog_r <= 1'b0;
			op_read_r <= 1'b0;
		end else begin
			unique case (state_r)
				JFA_ST_IDLE: begin
					if (start_any) begin
						state_r <= JFA_ST_WAIT;
						op_prog_r <= start_prog;
						op_read_r <= start_read;
					end
				end
				JFA_ST_WAIT: begin
					if (i_flash_done) begin
						state_r <= JFA_ST_IDLE;
					end
				end
			endcase
		end
	end

	// Flash request port, one pulse per operation
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_flash_req <= 1'b0;
			o_flash_cmd <= JFA_CMD_READ;
			o_flash_addr <= ADDR_RESET;
			o_flash_wdata <= DATA_BYTE_RESET;
			o_flash_scratch <= 1'b0;
		end else begin
			o_flash_req <= start_any;
			if (start_any) begin
				o_flash_scratch <= ctrl_r[CTRL_SCRATCH_BIT];
				o_flash_wdata <= wbyte;
				o_flash_addr <= addr_r;
				if (start_read) begin
					o_flash_cmd <= JFA_CMD_READ;
				end else if (start_prog) begin
					o_flash_cmd <= JFA_CMD_PROGRAM;
				end else if (mass_erase) begin
					// Address carries the exclusive top so the reserved area survives
					o_flash_cmd <= JFA_CMD_MASS_ERASE;
					o_flash_addr <= RESERVED_BASE;
				end else begin
					o_flash_cmd <= JFA_CMD_PAGE_ERASE;
				end
			end
		end
	end

endmodule

/* jfa_flash_access_props.sv */
// Port checks for the JTAG flash access block
`timescale 1ns/1ns
module jfa_flash_access_props import jfa_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_tck,
	input wire logic i_sel_ctrl,
	input wire logic i_sel_data,
	input wire logic i_capture_dr,
	input wire logic i_update_dr,
	input wire logic o_tdo,
	input wire logic o_flash_req,
	input wire jfa_cmd_e o_flash_cmd,
	input wire logic [ADDR_W-1:0] o_flash_addr,
	input wire logic i_flash_done
);
	logic busy_r;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Shadow of the operation in flight, cleared by the answer
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) busy_r <= 1'b0;
		else if (o_flash_req) busy_r <= 1'b1;
		else if (i_flash_done) busy_r <= 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	a_req_single: assert property (o_flash_req |=> !o_flash_req)
		else $error("request wider than one cycle");
	a_busy_no_req: assert property (busy_r |-> !o_flash_req)
		else $error("request while busy");
	a_cmd_hold: assert property (!o_flash_req |-> $stable(o_flash_cmd) && $stable(o_flash_addr))
		else $error("command changed without request");
	a_mass_addr: assert property (o_flash_req && o_flash_cmd == JFA_CMD_MASS_ERASE
		|-> o_flash_addr == RESERVED_BASE) else $error("mass erase address wrong");
	a_page_addr: assert property (o_flash_req && o_flash_cmd == JFA_CMD_PAGE_ERASE |->
		o_flash_addr != MASS_ERASE_ADDR_LO && o_flash_addr != MASS_ERASE_ADDR_HI)
		else $error("page erase at mass erase address");
	a_req_cause: assert property (o_flash_req |-> $past(i_tck, 2) &&
		($past(i_capture_dr, 2) || $past(i_update_dr, 2))) else $error("request without event");
	a_req_data_sel: assert property (o_flash_req |-> $past(i_sel_data, 2) &&
		!$past(i_sel_ctrl, 2)) else $error("request without data register");
	a_tdo_cause: assert property ($changed(o_tdo) |-> $past(i_tck, 2))
		else $error("tdo moved without link clock");
	c_prog: cover property (o_flash_req && o_flash_cmd == JFA_CMD_PROGRAM);
	c_read: cover property (o_flash_req && o_flash_cmd == JFA_CMD_READ);
	c_mass: cover property (o_flash_req && o_flash_cmd == JFA_CMD_MASS_ERASE);
endmodule
bind jfa_flash_access jfa_flash_access_props u_props (.i_sys_clk, .i_rst_n, .i_tck,
	.i_sel_ctrl, .i_sel_data, .i_capture_dr, .i_update_dr, .o_tdo, .o_flash_req,
	.o_flash_cmd, .o_flash_addr, .i_flash_done);

/* jfa_flash_model.sv */
// Behavioural flash array answering each request after a fixed delay
`timescale 1ns/1ns
module jfa_flash_model import jfa_pkg::*; #(
	parameter int LAT = 300
) (
	input wire logic i_sys_clk,
	input wire logic i_req,
	input wire jfa_cmd_e i_cmd,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [BYTE_W-1:0] i_wdata,
	input wire logic i_scratch,
	output logic o_done,
	output logic o_fail,
	output logic [BYTE_W-1:0] o_rdata
);
	// Only the low address byte is kept, so one page stands for a whole array
	logic [BYTE_W-1:0] mem[2][256];
	int cnt = 0;
	initial begin
		o_done = 1'b0;
		o_fail = 1'b0;
		o_rdata = 8'h5a;
		foreach (mem[a, b]) mem[a][b] = 8'hff;
	end
	always @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		o_rdata <= ~o_rdata;
		cnt <= (cnt > 0) ? cnt - 1 : 0;
		if (i_req) cnt <= LAT;
		if (cnt == 1) begin
			o_done <= 1'b1;
			o_fail <= i_cmd == JFA_CMD_PROGRAM && i_addr >= RESERVED_BASE; // Locked
			if (i_cmd == JFA_CMD_READ) o_rdata <= mem[i_scratch][i_addr[7:0]];
			if (i_cmd == JFA_CMD_PROGRAM && i_addr < RESERVED_BASE) mem[i_scratch][i_addr[7:0]] <= i_wdata;
			if (i_cmd > JFA_CMD_PROGRAM) for (int k = 0; k < 256; k++) mem[i_scratch][k] <= 8'hff;
		end
	end
endmodule

/* testbench.sv */
// Bench driving the link registers against a flash model
`timescale 1ns/1ns
module testbench import jfa_pkg::*; ;
	logic clk = 0, rst_n = 0, tck = 0, tdi = 0, sc = 0, sd = 0, sa = 0, cap = 0, sh = 0, up = 0;
	logic tdo, req, scr, done, fail, lscr;
	jfa_cmd_e cmd, lcmd;
	logic [16:0] fa, la, got;
	logic [7:0] wd, rd, lw;
	int err_count = 0, n_compared = 0, cyc = 0, nreq = 0, n0;
	initial forever #5 clk = ~clk;
	jfa_flash_access u_jfa_flash_access (.i_sys_clk(clk), .i_rst_n(rst_n), .i_tck(tck),
		.i_tdi(tdi), .i_sel_ctrl(sc), .i_sel_data(sd), .i_sel_addr(sa), .i_capture_dr(cap),
		.i_shift_dr(sh), .i_update_dr(up), .o_tdo(tdo), .o_flash_req(req), .o_flash_cmd(cmd),
		.o_flash_addr(fa), .o_flash_wdata(wd), .o_flash_scratch(scr), .i_flash_done(done),
		.i_flash_fail(fail), .i_flash_rdata(rd));
	jfa_flash_model u_jfa_flash_model (.i_sys_clk(clk), .i_req(req), .i_cmd(cmd), .i_addr(fa),
		.i_wdata(wd), .i_scratch(scr), .o_done(done), .o_fail(fail), .o_rdata(rd));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (req) begin
			nreq <= nreq + 1;
			{lcmd, la, lw, lscr} <= {cmd, fa, wd, scr};
		end
		if (cyc == 40000) begin
			err_count++;
			wrap_up;
		end
	end
	task automatic wrap_up;
		$display("Mismatches %0d of %0d compared", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [19:0] e, input logic [19:0] a);
		n_compared++;
		if (a !== e) begin
			err_count++;
			$display("Error at %0t: expected %h got %h", $time, e, a);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic tp;
		repeat (4) @(negedge clk);
		tck = 1;
		repeat (4) @(negedge clk);
		tck = 0;
	endtask
	// Capture, shift LSB first, then update only when asked
	task automatic scan(input logic [2:0] s, input int w, input logic [16:0] v, input logic u);
		got = '0;
		{sa, sd, sc} = s;
		cap = 1;
		tp;
		cap = 0;
		sh = 1;
		for (int i = 0; i < w; i++) begin
			got[i] = tdo;
			tdi = v[i];
			tp;
		end
		sh = 0;
		up = u;
		tp;
		up = 0;
	endtask
	task automatic wc(input logic [7:0] v);
		scan(3'b001, 8, 17'(v), 1);
	endtask
	task automatic wa(input logic [16:0] v);
		scan(3'b100, 17, v, 1);
	endtask
	task automatic wb(input logic [7:0] v);
		scan(3'b010, 10, 17'({v, 2'b00}), 1);
	endtask
	// Polls without update, so a finished read is not overwritten
	task automatic idle;
		for (int k = 0; k < 20; k++) begin
			scan(3'b010, 10, 17'h0, 0);
			if (got[0] === 1'b0) return;
		end
		chk(0, 1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		scan(3'b001, 8, 17'h0, 0);
		chk(CTRL_RESET, got);
		scan(3'b010, 10, 17'h0, 0);
		chk(0, got);
		scan(3'b100, 17, 17'h0, 0);
		chk(ADDR_RESET, got);
	endtask
	task automatic t_prog;
		wc(8'h10);
		wa(17'h10);
		n0 = nreq;
		wb(8'h5a);
		wb(8'h77);
		idle;
		chk(n0 + 1, nreq);
		chk(17'h168, got);
		chk({JFA_CMD_PROGRAM, 8'h5a, 1'b0}, {lcmd, lw, lscr});
		chk(17'h10, la);
		scan(3'b100, 17, 17'h0, 0);
		chk(17'h11, got);
	endtask
	task automatic t_store;
		wc(8'h00);
		n0 = nreq;
		wb(8'h3c);
		// Control and data selected together: only the control register takes the update
		scan(3'b011, 8, 17'h0, 1);
		scan(3'b010, 10, 17'h0, 0);
		chk(17'h0f0, got);
		chk(n0, nreq);
	endtask
	task automatic t_read;
		wc(8'h90);
		wa(17'h20);
		wb(8'hc3);
		idle;
		wc(8'h81);
		wa(17'h20);
		scan(3'b010, 10, 17'h0, 0);
		wc(8'h80);
		idle;
		chk(17'h30c, got);
		chk({JFA_CMD_READ, 1'b1}, {lcmd, lscr});
		wc(8'h01);
		scan(3'b010, 10, 17'h0, 0);
		wc(8'h00);
		idle;
		chk(17'h3fc, got);
	endtask
	// Single read mode: a capture starts a read only once the last byte was taken
	task automatic t_single;
		wc(8'h02);
		wa(17'h10);
		n0 = nreq;
		scan(3'b010, 10, 17'h0, 0);
		idle;
		chk(17'h168, got);
		chk(n0 + 1, nreq);
		scan(3'b010, 10, 17'h0, 0);
		idle;
		chk(n0 + 2, nreq);
	endtask
	task automatic t_erase;
		wc(8'h20);
		wa(17'h400);
		n0 = nreq;
		wb(8'h33);
		repeat (8) @(negedge clk);
		chk(n0, nreq);
		wb(ERASE_KEY);
		idle;
		chk({JFA_CMD_PAGE_ERASE, 17'h400}, {lcmd, la});
		scan(3'b100, 17, 17'h0, 0);
		chk(17'h400, got);
		for (int j = 0; j < 2; j++) begin
			wa(j ? MASS_ERASE_ADDR_HI : MASS_ERASE_ADDR_LO);
			wb(ERASE_KEY);
			idle;
			chk({JFA_CMD_MASS_ERASE, RESERVED_BASE}, {lcmd, la});
		end
	endtask
	task automatic t_fail;
		wc(8'h10);
		wa(RESERVED_BASE);
		wb(8'h11);
		idle;
		chk(17'h046, got);
		wa(17'h30);
		wb(8'h22);
		idle;
		chk(17'h088, got);
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1;
		t_reset;
		t_prog;
		t_store;
		t_read;
		t_single;
		t_erase;
		t_fail;
		wrap_up;
	end
endmodule
